//--- hdl/sdc_top.sv
// Purpose: Correction stage of a step-wise signed 32 by 32 divide
// Assumes: Init and divide steps load the accumulators and flags
//          through the load ports; instructions arrive one a cycle
// Notes:   Summary of operation follows
//
// Summary of operation
// RULE1: Decode remainder fix, source field picks register
// RULE2: Dividend sign clear: remainder fix does nothing
// RULE3: Sign set: high plus or minus source
// RULE4: Zero temporary: write high, bump quotient
// RULE5: Nonzero temporary: accumulators stay unchanged
// RULE6: Each correction completes in one cycle
// RULE7: Decode sign fix, no register operand
// RULE8: Equal sign flags: sign fix does nothing
// RULE9: Different sign flags: negate the quotient
// RULE10: Without multiplier both act as no-ops
// RULE11: Quotient in low, remainder in high
// RULE12: Unsigned division needs no correction instructions
// RULE13: Operations chosen from the two status flags
// RULE14: Temporary uses 32-bit wrapping arithmetic

`timescale 1ns/100ps

module sdc_top
  import sdc_pkg::*;
#(
  parameter bit          HAS_MULT = 1'b1,
  parameter int unsigned W        = DATA_W
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // Instruction issue
  input  wire logic                 INSN_VALID,
  input  wire logic [INSN_W-1:0]    INSN,
  // Status word flags, set by the init step
  input  wire logic                 DIVIDEND_SIGN_FLAG,
  input  wire logic                 DIVISOR_SIGN_FLAG,
  // Accumulator load from init and divide steps
  input  wire logic                 ACC_WR,
  input  wire logic [W-1:0]         ACC_HIGH_IN,
  input  wire logic [W-1:0]         ACC_LOW_IN,
  // General register write port
  input  wire logic                 GPR_WE,
  input  wire logic [GPR_IDX_W-1:0] GPR_IDX,
  input  wire logic [W-1:0]         GPR_DATA,
  // Results
  output logic      [W-1:0]         ACC_HIGH,
  output logic      [W-1:0]         ACC_LOW,
  output logic                      FIX_DONE,
  output logic                      FIX_APPLIED
);

  typedef struct packed {
    logic [W-1:0] accum_high;
    logic [W-1:0] accum_low;
    logic         done;
    logic         applied;
  } sdc_state_t;

  sdc_state_t st_r;
  sdc_state_t st_nxt;

  logic [W-1:0] source_register;
  logic [W-1:0] tmp_val;
  logic         is_fix_rem;
  logic         is_fix_sgn;

  // Opcode match: high byte plus a zero low nibble
  function automatic logic opc_match(input logic [INSN_W-1:0] insn,
                                     input logic [7:0]        hi);
    opc_match = (insn[OPC_HI_MSB:OPC_HI_LSB] == hi) &&
                (insn[OPC_LO_MSB:OPC_LO_LSB] == OPC_LO_ZERO);
  endfunction

  // Add or subtract; carry out is simply dropped
  function automatic logic [W-1:0] add_sub(input logic [W-1:0] a,
                                           input logic [W-1:0] b,
                                           input logic         sub);
    add_sub = sub ? (a - b) : (a + b);
  endfunction

  // RULE1: remainder fix decode
  assign is_fix_rem = INSN_VALID && opc_match(INSN, OPC_FIX_REM_HI);
  // RULE7: sign fix decode, source field ignored
  assign is_fix_sgn = INSN_VALID && opc_match(INSN, OPC_FIX_SGN_HI);

  // Divisor operand selected by the source field
  sdc_regfile #(
    .W (W),
    .N (NUM_GPR)
  ) u_regfile (
    .clk     (CLK),
    .rst_n   (RST_N),
    .we      (GPR_WE),
    .wr_idx  (GPR_IDX),
    .wr_data (GPR_DATA),
    .rd_idx  (INSN[SRC_MSB:SRC_LSB]),
    .rd_data (source_register)
  );

  // RULE3: add when divisor positive, subtract when negative
  // RULE14: 32-bit wrap, no carry kept
  assign tmp_val = add_sub(st_r.accum_high, source_register,
                           DIVISOR_SIGN_FLAG);

  // Next state; a correction wins over a same-cycle accumulator load,
  // since the step sequence never overlaps the two
  always_comb begin
    st_nxt         = st_r;
    st_nxt.done    = 1'b0;
    st_nxt.applied = 1'b0;
    if (is_fix_rem || is_fix_sgn) begin
      // RULE6: single-cycle completion
      st_nxt.done = 1'b1;
      // RULE10: no multiplier option means plain no-op
      if (HAS_MULT) begin
        // RULE13: flags pick the operation
        if (is_fix_rem) begin
          // RULE2: dividend positive leaves all alone
          if (DIVIDEND_SIGN_FLAG) begin
            // RULE4: zero temporary corrects both halves
            if (tmp_val == DATA_ZERO) begin
              st_nxt.accum_high = tmp_val;
              st_nxt.accum_low  = st_r.accum_low + DATA_ONE;
              st_nxt.applied    = 1'b1;
            end
            // RULE5: nonzero temporary changes nothing
          end
        end else begin
          // RULE8: equal signs keep the quotient
          // RULE9: different signs negate the quotient
          if (DIVIDEND_SIGN_FLAG != DIVISOR_SIGN_FLAG) begin
            st_nxt.accum_low = DATA_ZERO - st_r.accum_low;
            st_nxt.applied   = 1'b1;
          end
        end
      end
    end else if (ACC_WR) begin
      st_nxt.accum_high = ACC_HIGH_IN;
      st_nxt.accum_low  = ACC_LOW_IN;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r.accum_high <= ACC_RST;
      st_r.accum_low  <= ACC_RST;
      st_r.done       <= 1'b0;
      st_r.applied    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // RULE11: quotient low, remainder high, straight from flops
  assign ACC_HIGH    = st_r.accum_high;
  assign ACC_LOW     = st_r.accum_low;
  assign FIX_DONE    = st_r.done;
  assign FIX_APPLIED = st_r.applied;

endmodule

//--- include/sdc_pkg.sv
// Purpose: Shared constants for the signed divide correction stage
// Assumes: 16-bit instruction words, 32-bit data path
// Notes:   Opcode fields are matched as high byte plus low nibble

package sdc_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned INSN_W    = 16;
  localparam int unsigned NUM_GPR   = 16;
  localparam int unsigned GPR_IDX_W = 4;

  // Instruction fields
  localparam int unsigned OPC_HI_MSB = 15;
  localparam int unsigned OPC_HI_LSB = 8;
  localparam int unsigned SRC_MSB    = 7;
  localparam int unsigned SRC_LSB    = 4;
  localparam int unsigned OPC_LO_MSB = 3;
  localparam int unsigned OPC_LO_LSB = 0;

  // Opcode patterns of the two correction instructions
  localparam logic [7:0] OPC_FIX_REM_HI = 8'h97;
  localparam logic [7:0] OPC_FIX_SGN_HI = 8'h9b;
  localparam logic [3:0] OPC_LO_ZERO    = 4'h0;

  // Reset values and arithmetic constants
  localparam logic [DATA_W-1:0] ACC_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ONE  = 32'h0000_0001;

  // Execution time of each correction instruction, in core cycles
  localparam int unsigned FIX_CYCLES = 1;

endpackage

//--- hdl/sdc_regfile.sv
// Purpose: Sixteen general registers feeding the divisor operand
// Assumes: One write port, one combinational read port
// Notes:   Write and read of the same index return the old value

`timescale 1ns/100ps

module sdc_regfile
  import sdc_pkg::*;
#(
  parameter int unsigned W = DATA_W,
  parameter int unsigned N = NUM_GPR
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Write port
  input  wire logic                 we,
  input  wire logic [GPR_IDX_W-1:0] wr_idx,
  input  wire logic [W-1:0]         wr_data,
  // Read port
  input  wire logic [GPR_IDX_W-1:0] rd_idx,
  output logic      [W-1:0]         rd_data
);

  typedef struct packed {
    logic [N-1:0][W-1:0] gpr;
  } sdc_rf_state_t;

  sdc_rf_state_t st_r;
  sdc_rf_state_t st_nxt;

  // Next state of the register array
  always_comb begin
    st_nxt = st_r;
    if (we) begin
      st_nxt.gpr[wr_idx] = wr_data;
    end
  end

  // Register the array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Combinational read, so the operand is ready within the issue cycle
  assign rd_data = st_r.gpr[rd_idx];

endmodule

//--- test/sdc_assertions.sv
// Purpose: Port-level checks for the correction stage
// Assumes: One clock, asynchronous active-low reset
// Notes:   Register file is unseen, so the zero test is judged by the bench
`timescale 1ns/100ps
module sdc_assertions
  import sdc_pkg::*;
#(
  parameter bit          HAS_MULT = 1'b1,
  parameter int unsigned W        = DATA_W
) (
  // Clock, reset and stimulus
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic              INSN_VALID,
  input wire logic [INSN_W-1:0] INSN,
  input wire logic              DIVIDEND_SIGN_FLAG,
  input wire logic              DIVISOR_SIGN_FLAG,
  input wire logic              ACC_WR,
  input wire logic [W-1:0]      ACC_HIGH_IN,
  input wire logic [W-1:0]      ACC_LOW_IN,
  // Results
  input wire logic [W-1:0]      ACC_HIGH,
  input wire logic [W-1:0]      ACC_LOW,
  input wire logic              FIX_DONE,
  input wire logic              FIX_APPLIED
);
  logic rem_hit;
  logic sgn_hit;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Decode, low nibble must be zero
  assign rem_hit = INSN_VALID && INSN[15:8] == OPC_FIX_REM_HI
                   && INSN[3:0] == OPC_LO_ZERO;
  assign sgn_hit = INSN_VALID && INSN[15:8] == OPC_FIX_SGN_HI
                   && INSN[3:0] == OPC_LO_ZERO;
  sequence s_rem_set;
    rem_hit && DIVIDEND_SIGN_FLAG;
  endsequence
  sequence s_sgn_diff;
    sgn_hit && DIVIDEND_SIGN_FLAG != DIVISOR_SIGN_FLAG && HAS_MULT;
  endsequence
  a_fix_one_cycle: assert property ((rem_hit || sgn_hit) |=> FIX_DONE)
    else $error("correction did not finish in one cycle");
  a_no_match_quiet: assert property (!(rem_hit || sgn_hit) |=>
    !FIX_DONE)
    else $error("done pulse without a matching opcode");
  a_rem_ds_clear: assert property (rem_hit && !DIVIDEND_SIGN_FLAG |=>
    $stable(ACC_HIGH) && $stable(ACC_LOW) && !FIX_APPLIED)
    else $error("remainder fix acted with dividend sign clear");
  a_rem_apply: assert property (s_rem_set |=> (FIX_APPLIED ?
    ACC_HIGH == DATA_ZERO && ACC_LOW == $past(ACC_LOW) + DATA_ONE
    : $stable(ACC_HIGH) && $stable(ACC_LOW)))
    else $error("remainder fix result wrong");
  a_sgn_same_hold: assert property (sgn_hit &&
    DIVIDEND_SIGN_FLAG == DIVISOR_SIGN_FLAG |=>
    $stable(ACC_LOW) && !FIX_APPLIED)
    else $error("sign fix acted with equal signs");
  a_sgn_negate: assert property (s_sgn_diff |=>
    ACC_LOW == DATA_ZERO - $past(ACC_LOW) && $stable(ACC_HIGH))
    else $error("quotient not negated");
  a_no_mult_nop: assert property (!HAS_MULT |-> !FIX_APPLIED)
    else $error("correction applied without multiplier");
  a_load_acc: assert property (ACC_WR && !(rem_hit || sgn_hit) |=>
    ACC_HIGH == $past(ACC_HIGH_IN) && ACC_LOW == $past(ACC_LOW_IN))
    else $error("accumulator load lost");
endmodule
bind sdc_top sdc_assertions #(.HAS_MULT(HAS_MULT), .W(W)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .INSN_VALID(INSN_VALID), .INSN(INSN),
  .DIVIDEND_SIGN_FLAG(DIVIDEND_SIGN_FLAG),
  .DIVISOR_SIGN_FLAG(DIVISOR_SIGN_FLAG), .ACC_WR(ACC_WR),
  .ACC_HIGH_IN(ACC_HIGH_IN), .ACC_LOW_IN(ACC_LOW_IN), .ACC_HIGH(ACC_HIGH),
  .ACC_LOW(ACC_LOW), .FIX_DONE(FIX_DONE), .FIX_APPLIED(FIX_APPLIED));

//--- test/testbench.sv
// Purpose: Self-checking bench for the correction stage
// Assumes: Inputs change on the falling clock edge
// Notes:   Accumulators are preloaded through the load port
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, iv = 1'b0, dsf = 1'b0, nsf = 1'b0;
  logic        awr = 1'b0, gwe = 1'b0, done, appl;
  logic [15:0] insn = 16'h0000;
  logic [3:0]  gix = 4'h0;
  logic [31:0] ahi = 32'h0, alo = 32'h0, gd = 32'h0, acc_h, acc_l;
  logic [31:0] nm_h, nm_l;
  logic        nm_done, nm_appl;
  int          failures = 0, checked = 0;
  always #20 clk = ~clk;
  sdc_top u_dut (.CLK(clk), .RST_N(rst_n), .INSN_VALID(iv), .INSN(insn),
    .DIVIDEND_SIGN_FLAG(dsf), .DIVISOR_SIGN_FLAG(nsf), .ACC_WR(awr),
    .ACC_HIGH_IN(ahi), .ACC_LOW_IN(alo), .GPR_WE(gwe), .GPR_IDX(gix),
    .GPR_DATA(gd), .ACC_HIGH(acc_h), .ACC_LOW(acc_l), .FIX_DONE(done),
    .FIX_APPLIED(appl));
  // Second copy built without the multiplier option, same stimulus
  sdc_top #(.HAS_MULT(1'b0)) u_dut_nm (.CLK(clk), .RST_N(rst_n),
    .INSN_VALID(iv), .INSN(insn), .DIVIDEND_SIGN_FLAG(dsf),
    .DIVISOR_SIGN_FLAG(nsf), .ACC_WR(awr), .ACC_HIGH_IN(ahi),
    .ACC_LOW_IN(alo), .GPR_WE(gwe), .GPR_IDX(gix), .GPR_DATA(gd),
    .ACC_HIGH(nm_h), .ACC_LOW(nm_l), .FIX_DONE(nm_done),
    .FIX_APPLIED(nm_appl));
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: acc %h not %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: flag %b not %b", $time, g, e);
    end
  endtask
  // Load strobe drops on the next falling edge, where the next step issues at once
  task automatic load(input logic [31:0] h, input logic [31:0] l);
    awr = 1'b1;
    ahi = h;
    alo = l;
    @(negedge clk) awr = 1'b0;
  endtask
  task automatic gpr(input logic [3:0] i, input logic [31:0] d);
    gwe = 1'b1;
    gix = i;
    gd  = d;
    @(negedge clk) gwe = 1'b0;
    @(negedge clk);
  endtask
  // One issue, results and both pulses judged one cycle later
  task automatic fix(input logic [15:0] i, input logic d, input logic n,
                     input logic [31:0] eh, input logic [31:0] el,
                     input logic ed, input logic ea);
    insn = i;
    dsf  = d;
    nsf  = n;
    iv   = 1'b1;
    @(negedge clk) iv = 1'b0;
    cmp32(acc_h, eh);
    cmp32(acc_l, el);
    cmp1(done, ed);
    cmp1(appl, ea);
    @(negedge clk);
  endtask
  task automatic t_rem;
    gpr(4'h1, 32'h5);
    gpr(4'h2, 32'h9);
    load(32'hffff_fffb, 32'h7);
    fix(16'h9711, 1'b1, 1'b0, 32'hffff_fffb, 32'h7, 1'b0, 1'b0);
    fix(16'h9710, 1'b0, 1'b0, 32'hffff_fffb, 32'h7, 1'b1, 1'b0);
    fix(16'h9710, 1'b1, 1'b0, 32'h0, 32'h8, 1'b1, 1'b1);
    fix(16'h9710, 1'b1, 1'b1, 32'h0, 32'h8, 1'b1, 1'b0);
    load(32'h9, 32'h3);
    fix(16'h9720, 1'b1, 1'b1, 32'h0, 32'h4, 1'b1, 1'b1);
    $display("test remainder fix done");
  endtask
  task automatic t_sgn;
    load(32'h0, 32'h5);
    fix(16'h9b00, 1'b1, 1'b0, 32'h0, 32'hffff_fffb, 1'b1, 1'b1);
    fix(16'h9bf0, 1'b1, 1'b1, 32'h0, 32'hffff_fffb, 1'b1, 1'b0);
    fix(16'h9b50, 1'b0, 1'b1, 32'h0, 32'h5, 1'b1, 1'b1);
    fix(16'h9b01, 1'b1, 1'b0, 32'h0, 32'h5, 1'b0, 1'b0);
    $display("test sign fix done");
  endtask
  // Option absent: pulse still comes, accumulators must not move
  task automatic t_nomult;
    load(32'hffff_fffb, 32'h7);
    insn = 16'h9710;
    dsf  = 1'b1;
    nsf  = 1'b0;
    iv   = 1'b1;
    @(negedge clk) iv = 1'b0;
    cmp32(acc_h, 32'h0);
    cmp32(nm_h, 32'hffff_fffb);
    cmp32(nm_l, 32'h7);
    cmp1(nm_done, 1'b1);
    cmp1(nm_appl, 1'b0);
    @(negedge clk);
    fix(16'h9b00, 1'b1, 1'b0, 32'h0, 32'hffff_fff8, 1'b1, 1'b1);
    cmp32(nm_l, 32'h7);
    $display("test without multiplier done");
  endtask
  // Unsigned result is final; no correction is ever issued
  task automatic t_unsigned;
    load(32'h3, 32'h2a);
    repeat (2) @(negedge clk);
    cmp32(acc_h, 32'h3);
    cmp32(acc_l, 32'h2a);
    cmp1(done, 1'b0);
    $display("test unsigned result done");
  endtask
  // Run is about fifty-five cycles; the limit leaves ample slack
  initial begin
    #20000;
    failures++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_rem;
    t_sgn;
    t_nomult;
    t_unsigned;
    report_and_stop;
  end
endmodule
